/* sim/gated_counter_host.sv */
// Purpose: host model, apb master for the counter block
// Assumes: zero or more wait states, ready sampled at rising edge
// Notes:   write data is scrambled once the bus is released
`timescale 1ns/1ps
module gated_counter_host (
   // clock
   input  wire logic        pclk,
   // apb master
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
   end
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
   endtask : xfer
endmodule : gated_counter_host

/* sim/gated_counter_modes_sva.sv */
// Purpose: port checks for the gated counter block
// Assumes: one pclk domain, async active-low reset
// Notes:   bound into every instance of the block
`timescale 1ns/1ps
module gated_counter_modes_sva
   import gated_counter_pkg::*;
#(
   parameter int N_CNT = NUM_COUNTERS,
   parameter int N_SRC = NUM_SOURCES
)(
   // clock, reset, apb
   input wire logic             pclk,
   input wire logic             presetn,
   input wire logic             psel,
   input wire logic             penable,
   input wire logic             pwrite,
   input wire logic [11:0]      paddr,
   input wire logic [31:0]      pwdata,
   input wire logic [31:0]      prdata,
   input wire logic             pready,
   input wire logic             pslverr,
   // counters
   input wire logic [N_SRC-1:0] count_source,
   input wire logic [N_CNT-1:0] terminal_count,
   input wire logic [N_CNT-1:0] armed,
   input wire logic             irq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic wr;
   assign wr = psel & penable & pwrite;
   a_tc_single_pulse: assert property (
      |terminal_count |=> (terminal_count & $past(terminal_count)) == '0)
      else $error("terminal count pulse longer than one cycle");
   a_tc_when_armed: assert property (
      |terminal_count |-> (terminal_count & ~$past(armed)) == '0)
      else $error("terminal count from a disarmed counter");
   a_tc_after_edge: assert property (
      |terminal_count |-> $past(count_source) != $past(count_source, 2)
         || $past(count_source, 2) != $past(count_source, 3))
      else $error("terminal count without a source edge");
   a_arm_write: assert property (
      wr && paddr == ADDR_ARM |=> (armed & $past(pwdata[N_CNT-1:0]))
         == $past(pwdata[N_CNT-1:0]))
      else $error("arm write did not arm");
   a_disarm_write: assert property (
      wr && paddr == ADDR_DISARM |=> (armed & $past(pwdata[N_CNT-1:0])) == '0)
      else $error("disarm write did not disarm");
   a_arm_cause: assert property (
      (armed & ~$past(armed)) != '0 |-> $past(wr && paddr == ADDR_ARM))
      else $error("counter armed without an arm write");
   a_ready_high: assert property (pready)
      else $error("apb ready low");
   a_err_in_access: assert property (pslverr |-> psel && penable)
      else $error("slave error outside access phase");
   a_err_read_zero: assert property (
      psel && penable && pslverr && !pwrite |-> prdata == '0)
      else $error("refused read returned data");
   a_irq_cause: assert property (
      $rose(irq) |-> |terminal_count || |$past(terminal_count)
         || $past(wr && paddr == ADDR_INT_MASK))
      else $error("interrupt without an event");
   c_tc: cover property (|terminal_count);
   c_disarm: cover property ($fell(|armed));
   c_err: cover property (pslverr);
   c_irq: cover property ($rose(irq));
endmodule : gated_counter_modes_sva
bind gated_counter_modes gated_counter_modes_sva #(.N_CNT(N_CNT),
   .N_SRC(N_SRC)) u_gated_counter_modes_sva (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .count_source(count_source),
   .terminal_count(terminal_count), .armed(armed), .irq(irq));

/* sim/gated_counter_modes_tb_top.sv */
// Purpose: self-checking bench for the gated counter block
// Assumes: sources toggle every 6 clocks, a 12-clock period equal to MIN_SRC_CYCLES at the rate ceiling
// Notes:   each counting scenario programs a channel before arming it
`timescale 1ns/1ps
module gated_counter_modes_tb_top;
   import gated_counter_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0]  src = 8'h00;
   logic [7:0]  gate = 8'h00;
   logic [7:0]  tc, armed;
   int          mismatches = 0;
   int          check_count = 0;
   int          cyc = 0;
   int          tcn[8] = '{default: 0};
   always #2 pclk = ~pclk;
   gated_counter_host u_gated_counter_host (.pclk(pclk), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   gated_counter_modes u_gated_counter_modes (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .count_source(src), .gate_in(gate),
      .terminal_count(tc), .armed(armed), .irq(irq));
   always @(posedge pclk)
   begin
      cyc++;
      for (int i = 0; i < 8; i++)
         if (tc[i] === 1'b1)
            tcn[i]++;
      if (cyc == 8000)
      begin
         mismatches++;
         final_report();
      end
   end
   task final_report;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      u_gated_counter_host.xfer(1'b1, a, d, r, e);
   endtask : wr
   task rdc(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      u_gated_counter_host.xfer(1'b0, a, 32'h0, r, e);
      chk(r, exp);
   endtask : rdc
   function automatic logic [11:0] ch(input int n, input logic [4:0] o);
      return ADDR_CH_BASE + 12'(n) * ADDR_CH_STRIDE + 12'(o);
   endfunction : ch
   // program mode, load and hold, then arm
   task setup(input int n, input logic [15:0] m, input logic [15:0] ld,
              input logic [15:0] hd);
      wr(ch(n, OFS_MODE), {16'h0, m});
      wr(ch(n, OFS_LOAD), {16'h0, ld});
      wr(ch(n, OFS_HOLD), {16'h0, hd});
      wr(ADDR_ARM, 32'(1) << n);
   endtask : setup
   task edges(input int s, input int n);
      repeat (n)
      begin
         src[s] <= 1'b1;
         repeat (6) @(posedge pclk);
         src[s] <= 1'b0;
         repeat (6) @(posedge pclk);
      end
   endtask : edges
   task t_regs;
      logic [31:0] r;
      logic        e;
      rdc(ch(0, OFS_MODE), 32'(MODE_RESET));
      rdc(ADDR_INT_MASK, 32'(MASK_RESET));
      rdc(ADDR_STATUS, 32'h0);
      wr(ch(7, OFS_LOAD), 32'h1234_abcd);
      rdc(ch(7, OFS_LOAD), 32'h0000_abcd);
      u_gated_counter_host.xfer(1'b0, 12'hffc, 32'h0, r, e);
      chk(e, 32'h1);
      chk(r, 32'h0);
   endtask : t_regs
   task t_once;
      wr(ADDR_INT_MASK, 32'h1);
      setup(0, 16'h0000, 16'h0002, 16'h0007);
      edges(0, 2);
      chk(tcn[0], 1);
      chk(armed[0], 0);
      chk(irq, 1);
      rdc(ch(0, OFS_COUNT), 32'h2);
      edges(0, 2);
      rdc(ch(0, OFS_COUNT), 32'h2);
      rdc(ADDR_INT_STATUS, 32'h1);
      @(posedge pclk);
      chk(irq, 0);
   endtask : t_once
   task t_alt;
      setup(1, 16'h0021, 16'h0003, 16'h0002);
      edges(0, 1);
      rdc(ch(1, OFS_COUNT), 32'h3);
      edges(1, 3);
      chk(tcn[1], 1);
      chk(armed[1], 1);
      rdc(ch(1, OFS_COUNT), 32'h2);
      edges(1, 2);
      chk(tcn[1], 2);
      chk(armed[1], 0);
      rdc(ch(1, OFS_COUNT), 32'h3);
      chk(irq, 0);
      rdc(ADDR_INT_STATUS, 32'h2);
   endtask : t_alt
   task t_rep;
      setup(2, 16'h0012, 16'h0002, 16'h0000);
      edges(2, 6);
      chk(tcn[2], 3);
      chk(armed[2], 1);
      wr(ADDR_DISARM, 32'h4);
      @(posedge pclk);
      chk(armed[2], 0);
   endtask : t_rep
   task t_level;
      setup(3, 16'h1043, 16'h0005, 16'h0000);
      edges(3, 2);
      rdc(ch(3, OFS_COUNT), 32'h5);
      gate[3] <= 1'b1;
      edges(3, 2);
      rdc(ch(3, OFS_COUNT), 32'h3);
      gate[3] <= 1'b0;
   endtask : t_level
   task t_edge;
      setup(4, 16'h2054, 16'h0005, 16'h0000);
      edges(4, 2);
      rdc(ch(4, OFS_COUNT), 32'h5);
      gate[4] <= 1'b1;
      // the start latch must be set before the first source edge
      @(posedge pclk);
      edges(4, 2);
      rdc(ch(4, OFS_COUNT), 32'h3);
      gate[4] <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(armed[4], 0);
      setup(5, 16'h2015, 16'h0002, 16'h0000);
      gate[5] <= 1'b1;
      @(posedge pclk);
      edges(5, 3);
      chk(tcn[5], 1);
      chk(armed[5], 0);
      setup(6, 16'h2036, 16'h0001, 16'h0001);
      gate[6] <= 1'b1;
      @(posedge pclk);
      edges(6, 3);
      chk(tcn[6], 2);
      chk(armed[6], 0);
   endtask : t_edge
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_once();
      t_alt();
      t_rep();
      t_level();
      t_edge();
      final_report();
   end
endmodule : gated_counter_modes_tb_top

/* verilog/gated_counter_modes.sv */
// Purpose: eight independent 16-bit down counters with gating modes
// Assumes: source and gate inputs synchronous to pclk, APB register access
// Notes:   while armed and let through by the gate mode, a count happens on each rising edge of the selected source
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module gated_counter_modes
   import gated_counter_pkg::*;
#(
   parameter int N_CNT  = NUM_COUNTERS,
   parameter int CW     = COUNT_WIDTH,
   parameter int N_SRC  = NUM_SOURCES
)(
   // clock and reset
   input  wire logic                pclk,
   input  wire logic                presetn,
   // apb slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   // counter inputs
   input  wire logic [N_SRC-1:0]    count_source,
   input  wire logic [N_CNT-1:0]    gate_in,
   // counter outputs
   output logic      [N_CNT-1:0]    terminal_count,
   output logic      [N_CNT-1:0]    armed,
   output logic                     irq
);

   initial
   begin
      if (N_CNT != NUM_COUNTERS || CW != COUNT_WIDTH || N_SRC != NUM_SOURCES)
         $error("gated_counter_modes: unsupported parameter values");
   end

   logic [MODE_WIDTH-1:0] mode      [N_CNT];
   logic [CW-1:0]         load_reg  [N_CNT];
   logic [CW-1:0]         hold_reg  [N_CNT];
   logic [CW-1:0]         count     [N_CNT];
   logic [N_CNT-1:0]      use_hold;
   logic [N_CNT-1:0]      tc_seen;
   logic [N_CNT-1:0]      running;
   logic [N_SRC-1:0]      src_prev;
   logic [N_CNT-1:0]      gate_prev;
   logic [N_CNT-1:0]      int_status;
   logic [N_CNT-1:0]      int_mask;

   // apb decode
   logic                  wr_en;
   logic                  rd_en;
   logic                  ch_hit;
   logic [2:0]            ch_idx;
   logic [4:0]            ch_ofs;
   logic [11:0]           ch_rel;
   logic                  addr_ok;
   logic [N_CNT-1:0]      arm_req;
   logic [N_CNT-1:0]      disarm_req;
   logic                  status_rd;

   assign ch_rel    = paddr - ADDR_CH_BASE;
   assign ch_hit    = paddr >= ADDR_CH_BASE &&
                      paddr < ADDR_CH_BASE + 12'(N_CNT) * ADDR_CH_STRIDE;
   assign ch_idx    = ch_rel[7:5];
   assign ch_ofs    = ch_rel[4:0];
   assign wr_en     = psel && penable && pwrite;
   assign rd_en     = psel && penable && !pwrite;
   assign pready    = 1'b1;
   assign pslverr   = psel && penable && !addr_ok;
   assign status_rd = rd_en && paddr == ADDR_INT_STATUS;
   assign arm_req   = (wr_en && paddr == ADDR_ARM) ?
                      pwdata[N_CNT-1:0] : '0;
   assign disarm_req = (wr_en && paddr == ADDR_DISARM) ?
                      pwdata[N_CNT-1:0] : '0;

   always_comb
   begin
      addr_ok = 1'b0;
      if (paddr == ADDR_ARM || paddr == ADDR_DISARM ||
          paddr == ADDR_STATUS || paddr == ADDR_INT_STATUS ||
          paddr == ADDR_INT_MASK)
         addr_ok = 1'b1;
      else if (ch_hit && (ch_ofs == OFS_MODE || ch_ofs == OFS_LOAD ||
               ch_ofs == OFS_HOLD || ch_ofs == OFS_COUNT))
         addr_ok = 1'b1;
   end

   // read data from flip-flops
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
      begin
         prdata <= 32'h0000_0000;
         if (paddr == ADDR_STATUS)
            prdata[N_CNT-1:0] <= running;
         else if (paddr == ADDR_INT_STATUS)
            prdata[N_CNT-1:0] <= int_status;
         else if (paddr == ADDR_INT_MASK)
            prdata[N_CNT-1:0] <= int_mask;
         else if (ch_hit)
         begin
            case (ch_ofs)
               OFS_MODE:  prdata[MODE_WIDTH-1:0] <= mode[ch_idx];
               OFS_LOAD:  prdata[CW-1:0] <= load_reg[ch_idx];
               OFS_HOLD:  prdata[CW-1:0] <= hold_reg[ch_idx];
               OFS_COUNT: prdata[CW-1:0] <= count[ch_idx];
               default:   prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // configuration registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < N_CNT; i++)
         begin
            mode[i]     <= MODE_RESET;
            load_reg[i] <= LOAD_RESET;
            hold_reg[i] <= HOLD_RESET;
         end
         int_mask <= MASK_RESET;
      end
      else if (wr_en)
      begin
         if (paddr == ADDR_INT_MASK)
            int_mask <= pwdata[N_CNT-1:0];
         else if (ch_hit)
         begin
            case (ch_ofs)
               OFS_MODE: mode[ch_idx]     <= pwdata[MODE_WIDTH-1:0];
               OFS_LOAD: load_reg[ch_idx] <= pwdata[CW-1:0];
               OFS_HOLD: hold_reg[ch_idx] <= pwdata[CW-1:0];
               default:  ;
            endcase
         end
      end
   end

   // input history for edge detection
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         src_prev  <= '0;
         gate_prev <= '0;
      end
      else
      begin
         src_prev  <= count_source;
         gate_prev <= gate_in;
      end
   end

   // per-channel decode
   logic [N_CNT-1:0] src_edge;
   logic [N_CNT-1:0] gate_rise;
   logic [N_CNT-1:0] gate_fall;
   logic [N_CNT-1:0] advance;
   logic [N_CNT-1:0] at_tc;
   logic [N_CNT-1:0] stop_now;
   // edge-gated start latch, set by a gate rise while armed
   logic [N_CNT-1:0] gate_started;
   gate_style_t      style [N_CNT];

   always_comb
   begin
      for (int i = 0; i < N_CNT; i++)
      begin
         logic [SRC_SEL_WIDTH-1:0] sel;
         logic [3:0]               gf;
         logic                     rep;
         logic                     alt;
         logic                     spc;
         sel = mode[i][MODE_SRC_LSB +: SRC_SEL_WIDTH];
         gf  = mode[i][MODE_GATE_LSB +: 4];
         rep = mode[i][MODE_REP_BIT];
         alt = mode[i][MODE_RELOAD_BIT];
         spc = mode[i][MODE_SPECIAL_BIT];
         // one source edge per pclk sample; 20 MHz leaves many samples
         src_edge[i]  = count_source[sel] && !src_prev[sel];
         gate_rise[i] = gate_in[i] && !gate_prev[i];
         gate_fall[i] = !gate_in[i] && gate_prev[i];
         case (gf)
            GATE_LEVEL: style[i] = gate_level_t_v;
            GATE_EDGE:  style[i] = gate_edge_t_v;
            default:    style[i] = gate_none_t_v;
         endcase
         // special gate only matters for edge gating
         case (style[i])
            gate_none_t_v:  advance[i] = running[i] && src_edge[i];
            gate_level_t_v: advance[i] = running[i] && src_edge[i] &&
                                         gate_in[i];
            default:        advance[i] = running[i] && src_edge[i] &&
                                         tc_seen[i] == 1'b0 &&
                                         gate_started[i];
         endcase
         at_tc[i] = advance[i] && count[i] == CW'(1);
         stop_now[i] = at_tc[i] && !rep && (!alt || use_hold[i]);
         if (style[i] == gate_edge_t_v && at_tc[i] && (!alt || use_hold[i]))
            stop_now[i] = 1'b1;
         if (style[i] == gate_edge_t_v && spc && gate_fall[i] &&
             gate_started[i])
            stop_now[i] = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         gate_started <= '0;
      else
      begin
         for (int i = 0; i < N_CNT; i++)
         begin
            if (arm_req[i] || disarm_req[i] || stop_now[i])
               gate_started[i] <= 1'b0;
            else if (running[i] && gate_rise[i])
               gate_started[i] <= 1'b1;
         end
      end
   end

   // counter cores
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < N_CNT; i++)
            count[i] <= '0;
         running  <= '0;
         use_hold <= '0;
         tc_seen  <= '0;
      end
      else
      begin
         for (int i = 0; i < N_CNT; i++)
         begin
            if (arm_req[i])
            begin
               count[i]    <= load_reg[i];
               running[i]  <= 1'b1;
               use_hold[i] <= 1'b0;
               tc_seen[i]  <= 1'b0;
            end
            else if (disarm_req[i])
               running[i] <= 1'b0;
            else if (advance[i])
            begin
               if (at_tc[i])
               begin
                  if (mode[i][MODE_RELOAD_BIT] && !use_hold[i])
                     count[i] <= hold_reg[i];
                  else
                     count[i] <= load_reg[i];
                  use_hold[i] <= mode[i][MODE_RELOAD_BIT] && !use_hold[i];
               end
               else
                  count[i] <= count[i] - CW'(1);
               if (stop_now[i])
                  running[i] <= mode[i][MODE_REP_BIT] &&
                                style[i] != gate_edge_t_v;
            end
            else if (stop_now[i])
               running[i] <= 1'b0;
         end
      end
   end

   // terminal count pulse
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         terminal_count <= '0;
      else
         terminal_count <= at_tc;
   end

   assign armed = running;

   // sticky events; a new event wins over the read clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         int_status <= '0;
      else if (status_rd)
         int_status <= at_tc;
      else
         int_status <= int_status | at_tc;
   end

   assign irq = |(int_status & int_mask);

endmodule : gated_counter_modes

/* verilog/gated_counter_pkg.sv */
// Purpose: constants shared by the eight-channel gated counter block
// Assumes: APB with 32-bit data, one word per register
// Notes:   per-channel registers repeat at a fixed stride
package gated_counter_pkg;

   localparam int          NUM_COUNTERS    = 8;
   localparam int          COUNT_WIDTH     = 16;
   localparam int          NUM_SOURCES     = 8;
   localparam int          SRC_SEL_WIDTH   = 3;

   // source rate ceiling and core clock, both in kHz
   localparam int          MAX_SRC_KHZ     = 20000;
   localparam int          PCLK_KHZ        = 250000;
   // core clocks per source period at the ceiling, rounded down
   localparam int          MIN_SRC_CYCLES  = PCLK_KHZ / MAX_SRC_KHZ;

   // global registers
   localparam logic [11:0] ADDR_ARM        = 12'h000;
   localparam logic [11:0] ADDR_DISARM     = 12'h004;
   localparam logic [11:0] ADDR_STATUS     = 12'h008;
   localparam logic [11:0] ADDR_INT_STATUS = 12'h00c;
   localparam logic [11:0] ADDR_INT_MASK   = 12'h010;
   // per-channel registers: base + channel * stride + field offset
   localparam logic [11:0] ADDR_CH_BASE    = 12'h100;
   localparam logic [11:0] ADDR_CH_STRIDE  = 12'h020;
   localparam logic [4:0]  OFS_MODE        = 5'h00;
   localparam logic [4:0]  OFS_LOAD        = 5'h04;
   localparam logic [4:0]  OFS_HOLD        = 5'h08;
   localparam logic [4:0]  OFS_COUNT       = 5'h0c;

   // mode word fields
   localparam int          MODE_SRC_LSB    = 0;
   localparam int          MODE_REP_BIT    = 4;
   localparam int          MODE_RELOAD_BIT = 5;
   localparam int          MODE_SPECIAL_BIT = 6;
   localparam int          MODE_GATE_LSB   = 12;
   localparam int          MODE_WIDTH      = 16;

   // gate control field codes
   localparam logic [3:0]  GATE_NONE       = 4'h0;
   localparam logic [3:0]  GATE_LEVEL      = 4'h1;
   localparam logic [3:0]  GATE_EDGE       = 4'h2;

   localparam logic [15:0] MODE_RESET      = 16'h0000;
   localparam logic [15:0] LOAD_RESET      = 16'h0000;
   localparam logic [15:0] HOLD_RESET      = 16'h0000;
   localparam logic [7:0]  MASK_RESET      = 8'h00;

   typedef enum logic [1:0] {gate_none_t_v, gate_level_t_v, gate_edge_t_v}
      gate_style_t;

endpackage : gated_counter_pkg
